// ==== design/stc_exec.sv ====
// Decode and execute of halfword/word stores, subtract, sync, trap and control-register write
`timescale 1ns/100ps
`default_nettype none

module stc_exec #(
    parameter bit HAS_DCACHE = 1'b1,
    parameter logic [31:0] HANDLER_ADDR = 32'h0000_0020
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] instr_pc,
    input wire logic [31:0] opa,
    input wire logic [31:0] opb,
    input wire logic [3:0] xlat_fault,
    output logic instr_done,
    output logic rc_we,
    output logic [4:0] rc_idx,
    output logic [31:0] rc_data,
    output logic ctl_we,
    output logic [4:0] control_reg_index,
    output logic [31:0] ctl_data,
    output logic redirect_valid,
    output logic [31:0] redirect_pc,
    output logic [31:0] exception_return_addr,
    output logic dbus_req,
    output logic [31:0] dbus_addr,
    output logic [31:0] dbus_wdata,
    output logic [3:0] dbus_be,
    input wire logic dbus_ack,
    output logic cache_wr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    stc_pkg::stc_state_e state_r;
    logic [1:0] status_r;
    logic [1:0] saved_status_r;
    logic [3:0] cause_r;
    logic [31:0] bus_writes_r;
    logic st_half_r;
    logic done_r;
    logic cache_wr_r;
    logic [5:0] op;
    logic [5:0] opx;
    logic [15:0] signed_offset_field;
    logic [4:0] debug_code_field;
    logic [31:0] eff_addr;
    logic is_sth;
    logic is_stw;
    logic is_store;
    logic is_io;
    logic is_sub;
    logic is_sync;
    logic is_trap;
    logic is_wrctl;
    logic user_mode;
    logic take;
    logic misalign;
    logic [3:0] st_cause;
    logic exc_go;
    logic [3:0] exc_cause;
    logic to_bus;
    logic apb_wr;

    // Field extraction and opcode decode
    assign op = instr_word[5:0];
    assign opx = instr_word[16:11];
    assign signed_offset_field = instr_word[21:6];
    assign debug_code_field = instr_word[10:6]; // Read only as the control index; trap ignores it
    assign is_sth = (op == stc_pkg::OP_STH) || (op == stc_pkg::OP_STHIO);
    assign is_stw = (op == stc_pkg::OP_STW) || (op == stc_pkg::OP_STWIO);
    assign is_store = is_sth || is_stw;
    assign is_io = (op == stc_pkg::OP_STHIO) || (op == stc_pkg::OP_STWIO);
    assign is_sub = (op == stc_pkg::OP_RTYPE) && (opx == stc_pkg::OPX_SUB);
    assign is_sync = (op == stc_pkg::OP_RTYPE) && (opx == stc_pkg::OPX_SYNC)
        && (instr_word[31:17] == 15'h0000) && (instr_word[10:6] == 5'h00);
    assign is_trap = (op == stc_pkg::OP_RTYPE) && (opx == stc_pkg::OPX_TRAP)
        && (instr_word[31:22] == 10'h000) && (instr_word[21:17] == stc_pkg::TRAP_C_IDX);
    assign is_wrctl = (op == stc_pkg::OP_RTYPE) && (opx == stc_pkg::OPX_WRCTL);
    assign user_mode = status_r[stc_pkg::USER_BIT];
    assign instr_ready = (state_r == stc_pkg::ST_IDLE);
    assign take = instr_valid && instr_ready;

    // Effective address and alignment check
    assign eff_addr = opa + {{16{signed_offset_field[15]}}, signed_offset_field};
    assign misalign = is_sth ? eff_addr[0] : (eff_addr[1:0] != 2'b00);

    // Store fault priority: alignment first so no partial write issues
    always_comb begin
        if (misalign) begin
            st_cause = stc_pkg::CAUSE_MISALIGN;
        end else if (user_mode && (eff_addr >= stc_pkg::SUPV_BASE)) begin
            st_cause = stc_pkg::CAUSE_SUPV_DATA;
        end else if (xlat_fault[stc_pkg::FLT_PERM]) begin
            st_cause = stc_pkg::CAUSE_TLB_PERM;
        end else if (xlat_fault[stc_pkg::FLT_FAST]) begin
            st_cause = stc_pkg::CAUSE_TLB_FAST;
        end else if (xlat_fault[stc_pkg::FLT_DOUBLE]) begin
            st_cause = stc_pkg::CAUSE_TLB_DOUBLE;
        end else if (xlat_fault[stc_pkg::FLT_MPU]) begin
            st_cause = stc_pkg::CAUSE_MPU;
        end else begin
            st_cause = stc_pkg::CAUSE_NONE;
        end
    end

    // Exception selection for the taken instruction
    always_comb begin
        if (is_trap) begin
            exc_cause = stc_pkg::CAUSE_TRAP;
        end else if (is_wrctl && user_mode) begin
            exc_cause = stc_pkg::CAUSE_SUPV_INSN;
        end else if (is_store) begin
            exc_cause = st_cause;
        end else begin
            exc_cause = stc_pkg::CAUSE_NONE;
        end
    end
    assign exc_go = take && (exc_cause != stc_pkg::CAUSE_NONE);
    // Uncached forms reach the bus unless they fault; without a cache plain stores do too
    assign to_bus = take && is_store && !exc_go && (is_io || !HAS_DCACHE);

    // Store sequencer: one bus write outstanding at most, so the core stays in order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= stc_pkg::ST_IDLE;
            dbus_req <= 1'b0;
        end else begin
            unique case (state_r)
                stc_pkg::ST_IDLE: begin
                    if (to_bus) begin
                        state_r <= stc_pkg::ST_BUS;
                        dbus_req <= 1'b1;
                    end
                end
                stc_pkg::ST_BUS: begin
                    if (dbus_ack) begin
                        state_r <= stc_pkg::ST_IDLE;
                        dbus_req <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Store address, lane data and byte enables
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dbus_addr <= 32'h0000_0000;
            dbus_wdata <= 32'h0000_0000;
            dbus_be <= 4'h0;
            st_half_r <= 1'b0;
        end else if (take && is_store && !exc_go) begin
            dbus_addr <= {eff_addr[31:2], 2'b00};
            st_half_r <= is_sth;
            if (is_sth) begin
                dbus_wdata <= {opb[15:0], opb[15:0]};
                dbus_be <= eff_addr[1] ? 4'hc : 4'h3;
            end else begin
                dbus_wdata <= opb;
                dbus_be <= 4'hf;
            end
        end
    end

    // Completion and cache write pulses; sync completes at once as nothing is pending
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            cache_wr_r <= 1'b0;
        end else begin
            done_r <= (take && !to_bus) || (state_r == stc_pkg::ST_BUS && dbus_ack);
            cache_wr_r <= take && is_store && !exc_go && is_io == 1'b0 && HAS_DCACHE;
        end
    end
    assign instr_done = done_r;
    assign cache_wr = cache_wr_r;

    // Subtract writeback
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rc_we <= 1'b0;
            rc_idx <= 5'h00;
            rc_data <= 32'h0000_0000;
        end else begin
            rc_we <= take && is_sub;
            if (take && is_sub) begin
                rc_idx <= instr_word[21:17];
                rc_data <= opa - opb;
            end
        end
    end

    // Control-register write, refused in user mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_we <= 1'b0;
            control_reg_index <= 5'h00;
            ctl_data <= 32'h0000_0000;
        end else begin
            ctl_we <= take && is_wrctl && !user_mode;
            if (take && is_wrctl && !user_mode) begin
                control_reg_index <= debug_code_field;
                ctl_data <= opa;
            end
        end
    end

    // Exception entry: save status, mask and drop to supervisor, vector to the handler
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            redirect_valid <= 1'b0;
            redirect_pc <= 32'h0000_0000;
            exception_return_addr <= 32'h0000_0000;
            cause_r <= stc_pkg::CAUSE_NONE;
        end else begin
            redirect_valid <= exc_go;
            if (exc_go) begin
                redirect_pc <= HANDLER_ADDR;
                exception_return_addr <= instr_pc + stc_pkg::PC_STEP;
                cause_r <= exc_cause;
            end
        end
    end

    // Status: hardware exception entry wins over a same-cycle software write
    assign apb_wr = psel && penable && pwrite && (paddr == stc_pkg::REG_STATUS);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= stc_pkg::STATUS_RST;
            saved_status_r <= stc_pkg::STATUS_RST;
        end else if (exc_go) begin
            saved_status_r <= status_r;
            status_r <= 2'b00;
        end else if (apb_wr) begin
            status_r <= pwdata[1:0];
        end
    end

    // Count of completed bus writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_writes_r <= 32'h0000_0000;
        end else if (state_r == stc_pkg::ST_BUS && dbus_ack) begin
            bus_writes_r <= bus_writes_r + 32'h0000_0001;
        end
    end

    // APB read mux, zero wait states, error on unmapped addresses
    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        unique case (paddr)
            stc_pkg::REG_STATUS: prdata = {30'h0000_0000, status_r};
            stc_pkg::REG_SAVED_STATUS: prdata = {30'h0000_0000, saved_status_r};
            stc_pkg::REG_EXC_RET: prdata = exception_return_addr;
            stc_pkg::REG_CAUSE: prdata = {28'h000_0000, cause_r};
            stc_pkg::REG_BUS_WRITES: prdata = bus_writes_r;
            default: begin
                prdata = 32'h0000_0000;
                pslverr = psel && penable;
            end
        endcase
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    half_lanes_a: assert property (dbus_req && st_half_r |-> (dbus_be == 4'h3 || dbus_be == 4'hc))
        else $error("halfword store lanes wrong");
    word_lanes_a: assert property (dbus_req && !st_half_r |-> dbus_be == 4'hf)
        else $error("word store lanes not all enabled");
    misalign_blocks_a: assert property (take && is_store && misalign
        |=> !dbus_req && !cache_wr && redirect_valid && cause_r == stc_pkg::CAUSE_MISALIGN)
        else $error("misaligned store not stopped");
    io_bus_a: assert property (take && is_store && is_io && !exc_go
        |=> dbus_req && dbus_addr[1:0] == 2'b00 && dbus_addr[31:2] == $past(eff_addr[31:2]))
        else $error("uncached store missed bus");
    bus_hold_a: assert property (dbus_req && !dbus_ack |=> dbus_req && $stable(dbus_addr) && $stable(dbus_wdata))
        else $error("bus request dropped early");
    sub_result_a: assert property (take && is_sub |=> rc_we && rc_data == $past(opa) - $past(opb))
        else $error("subtract result wrong");
    trap_entry_a: assert property (take && is_trap |=> redirect_valid && redirect_pc == HANDLER_ADDR
        && exception_return_addr == $past(instr_pc) + stc_pkg::PC_STEP)
        else $error("trap entry wrong");
    trap_status_a: assert property (take && is_trap |=> status_r == 2'b00 && saved_status_r == $past(status_r))
        else $error("trap status save wrong");
    wrctl_user_a: assert property (take && is_wrctl && user_mode |=> !ctl_we ##0
        cause_r == stc_pkg::CAUSE_SUPV_INSN)
        else $error("user control write not refused");
    sync_quick_a: assert property (take && is_sync |=> instr_done && instr_ready)
        else $error("sync did not complete");

    half_store_c: cover property (take && is_sth ##1 dbus_req ##[1:8] dbus_ack);
    trap_c: cover property (take && is_trap ##1 redirect_valid);
    sub_c: cover property (take && is_sub ##1 rc_we);
    cache_c: cover property (cache_wr);
endmodule // stc_exec

`default_nettype wire

// ==== shared/stc_pkg.sv ====
// Shared constants for the store, subtract, trap and control-write execute block
package stc_pkg;
    // Primary and secondary opcodes
    localparam logic [5:0] OP_STH = 6'h0d;
    localparam logic [5:0] OP_STHIO = 6'h2d;
    localparam logic [5:0] OP_STW = 6'h15;
    localparam logic [5:0] OP_STWIO = 6'h35;
    localparam logic [5:0] OP_RTYPE = 6'h3a;
    localparam logic [5:0] OPX_SUB = 6'h39;
    localparam logic [5:0] OPX_SYNC = 6'h36;
    localparam logic [5:0] OPX_TRAP = 6'h2d;
    localparam logic [5:0] OPX_WRCTL = 6'h2e;
    localparam logic [4:0] TRAP_C_IDX = 5'h1d;
    // Exception cause codes
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_TRAP = 4'h1;
    localparam logic [3:0] CAUSE_SUPV_INSN = 4'h2;
    localparam logic [3:0] CAUSE_MISALIGN = 4'h3;
    localparam logic [3:0] CAUSE_SUPV_DATA = 4'h4;
    localparam logic [3:0] CAUSE_TLB_PERM = 4'h5;
    localparam logic [3:0] CAUSE_TLB_FAST = 4'h6;
    localparam logic [3:0] CAUSE_TLB_DOUBLE = 4'h7;
    localparam logic [3:0] CAUSE_MPU = 4'h8;
    // Translation fault input bit positions
    localparam int FLT_PERM = 0;
    localparam int FLT_FAST = 1;
    localparam int FLT_DOUBLE = 2;
    localparam int FLT_MPU = 3;
    // Status field positions and reset value
    localparam int IRQ_EN_BIT = 0;
    localparam int USER_BIT = 1;
    localparam logic [1:0] STATUS_RST = 2'h0;
    // Supervisor-only data region starts here
    localparam logic [31:0] SUPV_BASE = 32'h8000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    // Register map, byte addresses
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_SAVED_STATUS = 12'h004;
    localparam logic [11:0] REG_EXC_RET = 12'h008;
    localparam logic [11:0] REG_CAUSE = 12'h00c;
    localparam logic [11:0] REG_BUS_WRITES = 12'h010;
    // Sequencer states
    typedef enum logic {ST_IDLE, ST_BUS} stc_state_e;
endpackage

// ==== test/stc_dbus_model.sv ====
// Data bus responder that accepts store writes after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module stc_dbus_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dbus_req,
    input wire logic [2:0] delay,
    output logic dbus_ack
);
    logic [2:0] wait_r;

    // Count wait cycles, then accept for one cycle only while a request stands
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 3'h0;
            dbus_ack <= 1'b0;
        end else if (dbus_req && !dbus_ack && wait_r >= delay) begin
            wait_r <= 3'h0;
            dbus_ack <= 1'b1;
        end else begin
            wait_r <= (dbus_req && !dbus_ack) ? wait_r + 3'h1 : 3'h0;
            dbus_ack <= 1'b0;
        end
    end
endmodule // stc_dbus_model
`default_nettype wire

// ==== test/stc_exec_tb_top.sv ====
// Self-checking bench for the store, subtract, trap and control-write block
`timescale 1ns/100ps
`default_nettype none
module stc_exec_tb_top;
    localparam logic [31:0] HANDLER = 32'h0000_0040;
    logic mclk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [31:0] instr_word = 32'h0, instr_pc = 32'h0, opa = 32'h0, opb = 32'h0, pwdata = 32'h0, q, a, w;
    logic [11:0] paddr = 12'h0;
    logic [3:0] xlat_fault = 4'h0;
    logic [2:0] delay = 3'h0;
    logic [15:0] imm;
    logic [5:0] ops [4] = '{stc_pkg::OP_STH, stc_pkg::OP_STHIO, stc_pkg::OP_STW, stc_pkg::OP_STWIO};
    wire logic instr_ready, instr_done, rc_we, ctl_we, redirect_valid, dbus_req, dbus_ack, cache_wr, pready, pslverr;
    wire logic [4:0] rc_idx, ctl_idx;
    wire logic [31:0] rc_data, ctl_data, redirect_pc, ret_addr, dbus_addr, dbus_wdata, prdata;
    wire logic [3:0] dbus_be;
    int miscompares = 0, checked = 0, seed = 3950, exp_bus = 0, k;
    logic [1:0] exp_status = 2'h0, exp_saved = 2'h0;

    stc_exec #(.HAS_DCACHE(1'b1), .HANDLER_ADDR(HANDLER)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_word(instr_word),
        .instr_pc(instr_pc), .opa(opa), .opb(opb), .xlat_fault(xlat_fault), .instr_done(instr_done), .rc_we(rc_we),
        .rc_idx(rc_idx), .rc_data(rc_data), .ctl_we(ctl_we), .control_reg_index(ctl_idx), .ctl_data(ctl_data),
        .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .exception_return_addr(ret_addr),
        .dbus_req(dbus_req), .dbus_addr(dbus_addr), .dbus_wdata(dbus_wdata), .dbus_be(dbus_be), .dbus_ack(dbus_ack),
        .cache_wr(cache_wr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    stc_dbus_model i_mem (.mclk(mclk), .rst_n(rst_n), .dbus_req(dbus_req), .delay(delay), .dbus_ack(dbus_ack));

    // 125 MHz clock
    always #4 mclk = ~mclk;

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next transfer never reassigns psel in the same step
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        cmp_val(q, exp);
    endtask

    function automatic logic [31:0] ity(input logic [5:0] op, input logic [15:0] im);
        return {5'h03, 5'h04, im, op};
    endfunction

    function automatic logic [31:0] rty(input logic [14:0] abc, input logic [5:0] opx, input logic [4:0] n);
        return {abc, opx, n, stc_pkg::OP_RTYPE};
    endfunction

    // Issue one instruction, gather every result pulse, compare with the reference model
    task automatic exec(input logic [31:0] iw, input logic [31:0] va, input logic [31:0] vb, input logic [3:0] f);
        logic [31:0] ea, g_rc, g_ctl, g_ad, g_wd, g_rp, g_ra, pc;
        logic [4:0] g_ri, g_ci;
        logic [3:0] g_be, cz;
        logic st, hw, io, trap, wrc;
        int n = 0, n_rc = 0, n_ctl = 0, n_rd = 0, n_cw = 0, n_bus = 0;
        pc = $random(seed);
        pc[1:0] = 2'h0;
        delay <= 3'($random(seed));
        instr_valid <= 1'b1;
        instr_word <= iw;
        instr_pc <= pc;
        opa <= va;
        opb <= vb;
        xlat_fault <= f;
        do @(posedge mclk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
            n_rc += (rc_we === 1'b1);
            n_ctl += (ctl_we === 1'b1);
            n_rd += (redirect_valid === 1'b1);
            n_cw += (cache_wr === 1'b1);
            n_bus += (dbus_req === 1'b1 && dbus_ack === 1'b1);
            if (rc_we === 1'b1) {g_ri, g_rc} = {rc_idx, rc_data};
            if (ctl_we === 1'b1) {g_ci, g_ctl} = {ctl_idx, ctl_data};
            if (redirect_valid === 1'b1) {g_rp, g_ra} = {redirect_pc, ret_addr};
            if (cache_wr === 1'b1 || dbus_ack === 1'b1) {g_ad, g_wd, g_be} = {dbus_addr, dbus_wdata, dbus_be};
        end while (instr_done !== 1'b1 && n < 60);
        ea = va + {{16{iw[21]}}, iw[21:6]};
        hw = iw[5:0] == stc_pkg::OP_STH || iw[5:0] == stc_pkg::OP_STHIO;
        io = iw[5:0] == stc_pkg::OP_STHIO || iw[5:0] == stc_pkg::OP_STWIO;
        st = hw || iw[5:0] == stc_pkg::OP_STW || iw[5:0] == stc_pkg::OP_STWIO;
        trap = iw == rty({10'h0, stc_pkg::TRAP_C_IDX}, stc_pkg::OPX_TRAP, iw[10:6]);
        wrc = iw[5:0] == stc_pkg::OP_RTYPE && iw[16:11] == stc_pkg::OPX_WRCTL;
        cz = stc_pkg::CAUSE_NONE;
        if (st && (hw ? ea[0] : ea[1:0] != 2'h0)) cz = stc_pkg::CAUSE_MISALIGN;
        else if (st && exp_status[stc_pkg::USER_BIT] && ea >= stc_pkg::SUPV_BASE) cz = stc_pkg::CAUSE_SUPV_DATA;
        else if (st && f != 4'h0) cz = f[0] ? stc_pkg::CAUSE_TLB_PERM : f[1] ? stc_pkg::CAUSE_TLB_FAST :
            f[2] ? stc_pkg::CAUSE_TLB_DOUBLE : stc_pkg::CAUSE_MPU;
        else if (trap) cz = stc_pkg::CAUSE_TRAP;
        else if (wrc && exp_status[stc_pkg::USER_BIT]) cz = stc_pkg::CAUSE_SUPV_INSN;
        cmp_val({31'h0, instr_done}, 32'h1);
        cmp_cnt(n_rd, cz != 4'h0);
        if (cz != 4'h0) cmp_val(g_rp, HANDLER);
        if (cz != 4'h0) cmp_val(g_ra, pc + stc_pkg::PC_STEP);
        cmp_cnt(n_bus, st && io && cz == 4'h0);
        cmp_cnt(n_cw, st && !io && cz == 4'h0);
        if (st && cz == 4'h0) begin
            cmp_val(g_ad, {ea[31:2], 2'h0});
            cmp_val(g_wd, hw ? {vb[15:0], vb[15:0]} : vb);
            cmp_val(32'(g_be), hw ? (ea[1] ? 32'hc : 32'h3) : 32'hf);
        end
        cmp_cnt(n_rc, iw[5:0] == stc_pkg::OP_RTYPE && iw[16:11] == stc_pkg::OPX_SUB);
        if (n_rc == 1) cmp_val(g_rc, va - vb);
        if (n_rc == 1) cmp_val(32'(g_ri), 32'(iw[21:17]));
        cmp_cnt(n_ctl, wrc && cz == 4'h0);
        if (n_ctl == 1) cmp_val(g_ctl, va);
        if (n_ctl == 1) cmp_val(32'(g_ci), 32'(iw[10:6]));
        if (cz != 4'h0) begin
            exp_saved = exp_status;
            exp_status = 2'h0;
        end
        exp_bus += (st && io && cz == 4'h0);
    endtask

    // Mode change through the status register
    task automatic set_status(input logic [1:0] s);
        apb(1'b1, stc_pkg::REG_STATUS, 32'(s));
        exp_status = s;
    endtask

    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out;
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        cmp_val({q[30:0], e}, 32'h1);
        exec(ity(stc_pkg::OP_STHIO, 16'h0006), 32'h0000_1000, 32'h1234_5678, 4'h0);
        exec(ity(stc_pkg::OP_STHIO, 16'hfffc), 32'h0000_1000, 32'h8765_4321, 4'h0);
        exec(ity(stc_pkg::OP_STWIO, 16'hfff8), 32'h0000_2000, 32'hdead_beef, 4'h0);
        exec(ity(stc_pkg::OP_STH, 16'h0002), 32'h0000_2000, 32'h0000_abcd, 4'h0);
        exec(ity(stc_pkg::OP_STW, 16'h0004), 32'h0000_2000, 32'h0bad_f00d, 4'h0);
        exec(ity(stc_pkg::OP_STH, 16'h0001), 32'h0000_2000, 32'h1, 4'h0);
        exec(ity(stc_pkg::OP_STWIO, 16'h0002), 32'h0000_2000, 32'h1, 4'h0);
        for (int i = 0; i < 4; i++) exec(ity(stc_pkg::OP_STWIO, 16'h0), 32'h3000, 32'h1, 4'(1 << i));
        exec(ity(stc_pkg::OP_STWIO, 16'h0001), 32'h3000, 32'h1, 4'hf);
        rd(stc_pkg::REG_CAUSE, 32'(stc_pkg::CAUSE_MISALIGN));
        exec(rty({5'h01, 5'h02, 5'h09}, stc_pkg::OPX_SUB, 5'h0), 32'h5, 32'h7, 4'h0);
        exec(rty(15'h0, stc_pkg::OPX_SYNC, 5'h0), 32'h0, 32'h0, 4'h0);
        exec(rty({5'h03, 10'h0}, stc_pkg::OPX_WRCTL, 5'h06), 32'h0123_4567, 32'h0, 4'h0);
        set_status(2'h3);
        exec(rty({10'h0, stc_pkg::TRAP_C_IDX}, stc_pkg::OPX_TRAP, 5'h1f), 32'h0, 32'h0, 4'h0);
        rd(stc_pkg::REG_SAVED_STATUS, 32'h3);
        rd(stc_pkg::REG_STATUS, 32'h0);
        rd(stc_pkg::REG_CAUSE, 32'(stc_pkg::CAUSE_TRAP));
        set_status(2'h2);
        exec(rty({5'h03, 10'h0}, stc_pkg::OPX_WRCTL, 5'h01), 32'h1, 32'h0, 4'h0);
        rd(stc_pkg::REG_CAUSE, 32'(stc_pkg::CAUSE_SUPV_INSN));
        set_status(2'h2);
        exec(ity(stc_pkg::OP_STWIO, 16'h0), 32'h7fff_fffc, 32'h2, 4'h0);
        exec(ity(stc_pkg::OP_STWIO, 16'h0), 32'h8000_0000, 32'h2, 4'h0);
        rd(stc_pkg::REG_CAUSE, 32'(stc_pkg::CAUSE_SUPV_DATA));
        for (int i = 0; i < 40; i++) begin
            k = $random(seed) & 7;
            imm = $random(seed);
            imm[0] = 1'b0;
            a = $random(seed);
            a[1:0] = 2'h0;
            w = k < 4 ? ity(ops[k], imm) : k == 4 ? rty({5'h01, 5'h02, imm[4:0]}, stc_pkg::OPX_SUB, 5'h0) :
                k == 5 ? rty(15'h0, stc_pkg::OPX_SYNC, 5'h0) :
                k == 6 ? rty({10'h0, stc_pkg::TRAP_C_IDX}, stc_pkg::OPX_TRAP, imm[9:5]) :
                rty({5'h03, 10'h0}, stc_pkg::OPX_WRCTL, imm[9:5]);
            exec(w, a, $random(seed), ($random(seed) & 7) == 0 ? 4'($random(seed)) : 4'h0);
        end
        rd(stc_pkg::REG_BUS_WRITES, 32'(exp_bus));
        rd(stc_pkg::REG_SAVED_STATUS, 32'(exp_saved));
        close_out;
    end
endmodule // stc_exec_tb_top
`default_nettype wire
